// file: rtl/adc_result_serial_port.sv
// serial result port and conversion controller of a small adc
// Notes on behaviour
// RULE1: host holds convert start low for 2 us
// RULE2: powered for power-up plus 9 us conversion
// RULE3: five-wire: results out, control in, separate lines
// RULE4: port is slave; host supplies serial clock
// RULE5: select low writes, select high reads
// RULE6: select rise drives top bit; skip first fall
// RULE7: ten result bits; eight may suffice
// RULE8: select stays high across split read bytes
// RULE9: select low then high before new read
// RULE10: output floats on chip select rise or select fall
// RULE11: read clears result until next conversion
// RULE12: write captures first eight rising edges only
// RULE13: select high then low before new write
// RULE14: works with chip select low, data joined
// RULE15: three-wire: select high drives top bit
// RULE16: three-wire: bits change from second falling edge
// RULE17: three-wire: pin turns input at select fall
// RULE18: start low at busy fall powers down
// RULE19: host waits 100 ns after read
// RULE20: channel defaults to temperature sensor
// RULE21: msb first, one bit per clock
`timescale 1ns/1ps
module adc_result_serial_port #(
    parameter bit THREE_WIRE = 1'b0 // one shared data pin
) (
    // system clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // convert start pin, active low
    input wire logic convert_start_n_i,
    // analog front end
    input wire logic [adc_port_pkg::RES_W-1:0] adc_code_i,
    output logic sample_o,
    // status and control towards the system
    output adc_port_pkg::conv_status_t status_o,
    output logic [adc_port_pkg::CH_W-1:0] channel_o,
    output logic [adc_port_pkg::CTRL_W-1:0] ctrl_o,
    // serial link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic rd_wr_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o
);
    // system domain state
    typedef struct packed {
        adc_port_pkg::conv_state_t st;
        logic cvs_n_prev;
        logic rd_wr_prev;
        logic tgl_prev;
        logic valid;
        logic [adc_port_pkg::RES_W-1:0] result;
        logic [adc_port_pkg::RES_W-1:0] rbuf;
        logic [adc_port_pkg::CTRL_W-1:0] ctrl;
    } sys_state_t;

    // falling-edge read counter, cleared while select is low
    typedef struct packed {
        logic [adc_port_pkg::CNT_W-1:0] cnt;
    } rd_state_t;

    // rising-edge write counter, cleared while select is high
    typedef struct packed {
        logic [adc_port_pkg::CNT_W-1:0] cnt;
    } wr_cnt_t;

    // write shifter and hand-over toggle, kept across frames
    typedef struct packed {
        logic [adc_port_pkg::CTRL_W-1:0] byte_v;
        logic tgl;
    } wr_data_t;

    // picks the bit that stands on the output for a count
    function automatic logic rd_bit(
        input logic [adc_port_pkg::RES_W-1:0] buf_v,
        input logic [adc_port_pkg::CNT_W-1:0] cnt
    );
        logic [adc_port_pkg::CNT_W-1:0] idx;
        idx = (cnt == '0) ? '0 : cnt - adc_port_pkg::CNT_ONE;
        if (cnt >= adc_port_pkg::RD_SAT) begin
            rd_bit = 1'b0;
        end else begin
            rd_bit = buf_v[adc_port_pkg::RES_W - 1 - int'(idx)];
        end
    endfunction

    sys_state_t sq;
    sys_state_t sd;
    rd_state_t rq;
    rd_state_t rd;
    wr_cnt_t wq;
    wr_cnt_t wd;
    wr_data_t dq;
    wr_data_t dd;

    adc_port_pkg::sys_pins_t pins_s; // synchronised pins
    logic tmr_start; // load the phase timer
    logic [adc_port_pkg::TMR_W-1:0] tmr_ld; // phase length
    logic tmr_done; // last cycle of a phase
    logic cvs_fall; // convert start fell
    logic cvs_rise; // convert start rose
    logic rd_wr_fall; // read frame ended
    logic rd_clr; // async clear of read count
    logic wr_clr; // async clear of write count

    // ---------------- system domain ----------------

    // pins and the write toggle cross by two flops
    bit_sync #(
        .W(3)
    ) u_sync (
        .clk_i(clk_sys_i),
        .reset_i(reset_i),
        .d_i({convert_start_n_i, rd_wr_i, dq.tgl}),
        .q_o(pins_s)
    );

    // times the power-up and conversion phases
    conv_timer #(
        .W(adc_port_pkg::TMR_W)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .start_i(tmr_start),
        .load_i(tmr_ld),
        .done_o(tmr_done)
    );

    // edges seen on the synchronised levels
    assign cvs_fall = sq.cvs_n_prev && !pins_s.cvs_n;
    assign cvs_rise = !sq.cvs_n_prev && pins_s.cvs_n;
    assign rd_wr_fall = sq.rd_wr_prev && !pins_s.rd_wr;

    // conversion controller, result store and control capture
    always_comb begin
        sd = sq;
        tmr_start = 1'b0;
        tmr_ld = adc_port_pkg::CONV_LD;
        sd.cvs_n_prev = pins_s.cvs_n;
        sd.rd_wr_prev = pins_s.rd_wr;
        sd.tgl_prev = pins_s.wr_tgl;
        // a finished read erases the result
        if (rd_wr_fall) begin
            sd.valid = 1'b0; // RULE11
        end
        case (sq.st)
            // powered, tracking the input
            adc_port_pkg::ST_IDLE: begin
                if (cvs_fall) begin
                    tmr_start = 1'b1;
                    sd.st = adc_port_pkg::ST_CONV;
                end
            end
            // busy for the conversion time
            adc_port_pkg::ST_CONV: begin
                if (tmr_done) begin
                    // a new result wins over a clear in this cycle
                    sd.valid = 1'b1;
                    sd.result = adc_code_i;
                    if (!pins_s.cvs_n) begin
                        sd.st = adc_port_pkg::ST_DOWN; // RULE18
                    end else begin
                        sd.st = adc_port_pkg::ST_IDLE;
                    end
                end
            end
            // powered down until convert start rises
            adc_port_pkg::ST_DOWN: begin
                if (cvs_rise) begin
                    tmr_start = 1'b1;
                    tmr_ld = adc_port_pkg::PWRUP_LD;
                    sd.st = adc_port_pkg::ST_WAKE; // RULE18
                end
            end
            // power-up time, then the conversion follows
            adc_port_pkg::ST_WAKE: begin
                if (tmr_done) begin
                    tmr_start = 1'b1; // RULE2
                    sd.st = adc_port_pkg::ST_CONV;
                end
            end
            default: begin
                sd.st = adc_port_pkg::ST_IDLE;
            end
        endcase
        // read buffer frozen while a read frame is open
        if (!pins_s.rd_wr) begin
            sd.rbuf = sd.valid ? sd.result : '0; // RULE8
        end
        // control byte is stable once the toggle arrives
        if (pins_s.wr_tgl != sq.tgl_prev) begin
            sd.ctrl = dq.byte_v; // RULE12
        end
    end

    // system register; channel resets to the sensor
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sq.st <= adc_port_pkg::ST_IDLE;
            sq.cvs_n_prev <= 1'b0; // same as the synchroniser, so no false fall
            sq.rd_wr_prev <= 1'b0;
            sq.tgl_prev <= 1'b0;
            sq.valid <= 1'b0;
            sq.result <= '0;
            sq.rbuf <= '0;
            sq.ctrl <= adc_port_pkg::CTRL_RST; // RULE20
        end else begin
            sq <= sd;
        end
    end

    // system outputs from state flops, except sample_o, decoded from the timer start
    assign status_o.busy = (sq.st == adc_port_pkg::ST_CONV);
    assign status_o.powered = (sq.st != adc_port_pkg::ST_DOWN);
    assign status_o.valid = sq.valid;
    assign sample_o = tmr_start && (sq.st != adc_port_pkg::ST_DOWN);
    assign ctrl_o = sq.ctrl;
    assign channel_o = sq.ctrl[adc_port_pkg::CH_LSB +: adc_port_pkg::CH_W];

    // ---------------- link domain ----------------

    // select low ends a read at once, without a clock
    assign rd_clr = reset_i || !rd_wr_i;
    // select high ends a write at once
    assign wr_clr = reset_i || rd_wr_i;

    // count falling edges; the first leaves the top bit
    always_comb begin
        rd = rq;
        if (rq.cnt < adc_port_pkg::RD_SAT) begin
            rd.cnt = rq.cnt + adc_port_pkg::CNT_ONE; // RULE6 RULE16
        end
    end

    // read counter on the falling serial clock
    always_ff @(negedge sclk_i or posedge rd_clr) begin // RULE4
        if (rd_clr) begin
            rq <= '0;
        end else begin
            rq <= rd;
        end
    end

    // count the first eight rising edges of a write
    always_comb begin
        wd = wq;
        if (wq.cnt < adc_port_pkg::WR_BITS) begin
            wd.cnt = wq.cnt + adc_port_pkg::CNT_ONE; // RULE12
        end
    end

    // write counter on the rising serial clock
    always_ff @(posedge sclk_i or posedge wr_clr) begin
        if (wr_clr) begin
            wq <= '0;
        end else begin
            wq <= wd;
        end
    end

    // shift in msb first; later cycles are ignored
    always_comb begin
        dd = dq;
        if (!rd_wr_i && wq.cnt < adc_port_pkg::WR_BITS) begin
            dd.byte_v = {dq.byte_v[adc_port_pkg::CTRL_W-2:0], sdi_i}; // RULE3 RULE12
            if (wq.cnt == adc_port_pkg::WR_BITS - adc_port_pkg::CNT_ONE) begin
                dd.tgl = !dq.tgl; // hand the byte over
            end
        end
    end

    // shifter keeps its byte until the next write starts
    always_ff @(posedge sclk_i or posedge reset_i) begin
        if (reset_i) begin
            dq <= '0;
        end else begin
            dq <= dd;
        end
    end

    // output bit: msb first, zero after ten bits
    assign sdo_o = rd_bit(sq.rbuf, rq.cnt); // RULE7 RULE21
    // drive only inside a read frame; chip select ignored on three wires
    assign sdo_oe_o = THREE_WIRE ? rd_wr_i : (rd_wr_i && !cs_n_i); // RULE10 RULE14 RULE15 RULE17

    // ---------------- checks ----------------

    logic [adc_port_pkg::TMR_W-1:0] busy_len_q; // cycles spent busy
    logic [adc_port_pkg::TMR_W-1:0] wake_len_q; // cycles spent waking

    // helper counters for the phase lengths
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            busy_len_q <= '0;
            wake_len_q <= '0;
        end else begin
            busy_len_q <= status_o.busy ? busy_len_q + 1'b1 : '0;
            wake_len_q <= (sq.st == adc_port_pkg::ST_WAKE) ? wake_len_q + 1'b1 : '0;
        end
    end

    a_busy_length: assert property ( // RULE2
        @(posedge clk_sys_i) disable iff (reset_i)
        $fell(status_o.busy) |-> busy_len_q == adc_port_pkg::CONV_LD
    ) else $error("conversion length wrong");

    a_wake_length: assert property ( // RULE2
        @(posedge clk_sys_i) disable iff (reset_i)
        (sq.st == adc_port_pkg::ST_WAKE) && tmr_done
        |=> status_o.busy && wake_len_q == adc_port_pkg::PWRUP_LD
    ) else $error("power-up length wrong");

    a_down_at_end: assert property ( // RULE18
        @(posedge clk_sys_i) disable iff (reset_i)
        status_o.busy && tmr_done && !pins_s.cvs_n
        |=> !status_o.powered && status_o.valid
    ) else $error("no power-down after conversion");

    a_wake_on_rise: assert property ( // RULE18
        @(posedge clk_sys_i) disable iff (reset_i)
        !status_o.powered && cvs_rise
        |=> status_o.powered && !status_o.busy
    ) else $error("no power-up on start rise");

    a_read_clears: assert property ( // RULE11
        @(posedge clk_sys_i) disable iff (reset_i)
        rd_wr_fall && !(status_o.busy && tmr_done)
        |=> !status_o.valid ##1 (sq.rbuf == '0 || status_o.valid)
    ) else $error("result survived a read");

    a_buf_frozen: assert property ( // RULE8
        @(posedge clk_sys_i) disable iff (reset_i)
        pins_s.rd_wr && $past(pins_s.rd_wr) |-> $stable(sq.rbuf)
    ) else $error("read buffer moved in a frame");

    a_ctrl_taken: assert property ( // RULE12
        @(posedge clk_sys_i) disable iff (reset_i)
        pins_s.wr_tgl != sq.tgl_prev |=> ctrl_o == $past(dq.byte_v)
    ) else $error("control byte not taken");

    a_write_stops: assert property ( // RULE12
        @(posedge sclk_i) disable iff (reset_i || rd_wr_i)
        wq.cnt == adc_port_pkg::WR_BITS |=> $stable(dq.byte_v) && $stable(dq.tgl)
    ) else $error("write shifted past eight bits");

    a_read_order: assert property ( // RULE6
        @(negedge sclk_i) disable iff (reset_i || !rd_wr_i)
        rq.cnt == adc_port_pkg::CNT_ONE |-> sdo_o == sq.rbuf[adc_port_pkg::RES_W-1]
    ) else $error("top bit left too early");

    c_mode_one: cover property (
        @(posedge clk_sys_i) disable iff (reset_i)
        $fell(status_o.busy) && status_o.powered
    );

    c_mode_two: cover property (
        @(posedge clk_sys_i) disable iff (reset_i)
        (sq.st == adc_port_pkg::ST_WAKE) && tmr_done
    );

    c_ctrl_write: cover property (
        @(posedge clk_sys_i) disable iff (reset_i)
        pins_s.wr_tgl != sq.tgl_prev
    );

    c_read_clear: cover property (
        @(posedge clk_sys_i) disable iff (reset_i)
        rd_wr_fall && status_o.valid
    );
endmodule // adc_result_serial_port

// file: rtl/adc_port_pkg.sv
// package: constants and types shared by the adc result serial port
package adc_port_pkg;
    // system clock and documented times, each in nanoseconds
    localparam int CLK_NS = 50;
    localparam int PWRUP_NS = 2000;
    localparam int CONV_NS = 9000;
    // least times round up to whole clock cycles
    localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    // timer width and load values
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] PWRUP_LD = TMR_W'(PWRUP_CYC);
    localparam logic [TMR_W-1:0] CONV_LD = TMR_W'(CONV_CYC);
    localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
    // result and control byte widths
    localparam int RES_W = 10;
    localparam int CTRL_W = 8;
    // channel field inside the control byte
    localparam int CH_LSB = 5;
    localparam int CH_W = 3;
    // control byte after reset: channel 0, the temperature sensor
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    // serial bit counters
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RD_SAT = 4'hb;
    localparam logic [CNT_W-1:0] WR_BITS = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // conversion controller states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CONV = 4'h2,
        ST_DOWN = 4'h4,
        ST_WAKE = 4'h8
    } conv_state_t;
    // status seen by the system side
    typedef struct packed {
        logic busy;
        logic powered;
        logic valid;
    } conv_status_t;
    // pins after the two-flop synchroniser
    typedef struct packed {
        logic cvs_n;
        logic rd_wr;
        logic wr_tgl;
    } sys_pins_t;
endpackage

// file: rtl/bit_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1 // number of independent levels
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // levels in and out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // first stage is read only by the second
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t q;
    sync_t d;

    // next state: shift one stage
    always_comb begin
        d.s1 = d_i;
        d.s2 = q.s1;
    end

    // register the stages
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign q_o = q.s2;
endmodule // bit_sync

// file: rtl/conv_timer.sv
// down counter that flags the last cycle of a timed phase
`timescale 1ns/1ps
module conv_timer #(
    parameter int W = 8 // counter width
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // load request and length
    input wire logic start_i,
    input wire logic [W-1:0] load_i,
    // high in the last cycle of the phase
    output logic done_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_t;
    tmr_t q;
    tmr_t d;

    // load wins over counting; stop at zero
    always_comb begin
        d = q;
        if (start_i) begin
            d.cnt = load_i;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    // counter register
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // phase of n cycles ends when one is left
    assign done_o = (q.cnt == W'(1));
endmodule // conv_timer

// file: tb/host_link_model.sv
// host model: drives the serial link of both port variants
`timescale 1ns/1ps
module host_link_model (
    // link pins towards the ports
    output logic sclk_o,
    output logic cs_n_o,
    output logic rd_wr_o,
    output logic sdi_o,
    // data and enables coming back
    input wire logic sdo5_i,
    input wire logic oe5_i,
    input wire logic sdo3_i,
    input wire logic oe3_i
);
    localparam realtime HALF = 62.5; // 125 ns link clock
    // link clock stands high outside frames
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b0; // sole device on the bus
        rd_wr_o = 1'b0;
        sdi_o = 1'b0;
    end
    // one falling then one rising link edge
    task automatic pulse();
        sclk_o = 1'b0; // host makes every clock
        #HALF;
        sclk_o = 1'b1;
        #HALF;
    endtask
    // read frame; bits sampled after each rising edge
    task automatic read(input int n, input logic cs_n, output logic [9:0] b5,
            output logic [9:0] b3, output logic o5, output logic o3);
        b5 = 10'h000;
        b3 = 10'h000;
        rd_wr_o = 1'b0; // low then high before a read
        cs_n_o = cs_n;
        #(2*HALF);
        rd_wr_o = 1'b1; // high selects a read
        #(2*HALF);
        for (int k = 0; k < n; k++) begin
            pulse(); // select held high over all bytes
            b5[9-k] = sdo5_i;
            b3[9-k] = sdo3_i;
        end
        o5 = oe5_i;
        o3 = oe3_i;
        rd_wr_o = 1'b0;
        cs_n_o = 1'b0;
        #(2*HALF);
    endtask
    // write frame; clocks past the eighth carry the wrong bits
    task automatic write(input logic [7:0] v, input int n);
        rd_wr_o = 1'b1; // high then low before a write
        #(2*HALF);
        rd_wr_o = 1'b0; // low selects a write
        #(2*HALF);
        for (int k = 0; k < n; k++) begin
            sdi_o = (k < 8) ? v[7-k] : ~v[k-8];
            pulse();
        end
        sdi_o = ~sdi_o; // released line must not keep its value
        #(4*HALF);
    endtask
    // read frame cut short by chip select or by select falling
    task automatic abort(input logic by_cs, output logic o5, output logic o3);
        rd_wr_o = 1'b1;
        #(2*HALF);
        pulse();
        if (by_cs) begin
            cs_n_o = 1'b1;
        end else begin
            rd_wr_o = 1'b0;
        end
        #1;
        o5 = oe5_i;
        o3 = oe3_i;
        rd_wr_o = 1'b0;
        cs_n_o = 1'b0;
        #(2*HALF);
    endtask
endmodule // host_link_model

// file: tb/adc_result_serial_port_tb_top.sv
// testbench: five-wire and three-wire ports against one host model
`timescale 1ns/1ps
module adc_result_serial_port_tb_top;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_n = 1'b1;
    logic [adc_port_pkg::RES_W-1:0] code = 10'h000;
    logic sclk, cs_n, rd_wr, sdi, sdo5, oe5, sdo3, oe3, pin3;
    logic pin5; // five-wire data in and out joined
    logic samp5; // five-wire sample pulse
    int samp_count = 0; // sample pulses seen
    adc_port_pkg::conv_status_t st5, st3;
    logic [adc_port_pkg::CH_W-1:0] ch5, ch3;
    logic [adc_port_pkg::CTRL_W-1:0] ctrl5, ctrl3;
    int fail_count = 0;
    int num_checks = 0;
    int run_q = 0; // busy cycles so far
    int last_len = 0; // length of the last busy phase
    // shared pin level: port drives while enabled, else the host
    assign pin3 = oe3 ? sdo3 : sdi;
    // five-wire lines tied together; deselected output shows the host
    assign pin5 = oe5 ? sdo5 : sdi;
    adc_result_serial_port #(.THREE_WIRE(1'b0)) i_dut (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .convert_start_n_i(start_n), .adc_code_i(code),
        .sample_o(samp5), .status_o(st5), .channel_o(ch5), .ctrl_o(ctrl5), .sclk_i(sclk),
        .cs_n_i(cs_n), .rd_wr_i(rd_wr), .sdi_i(pin5), .sdo_o(sdo5), .sdo_oe_o(oe5));
    adc_result_serial_port #(.THREE_WIRE(1'b1)) i_dut3 (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .convert_start_n_i(start_n), .adc_code_i(code),
        .sample_o(), .status_o(st3), .channel_o(ch3), .ctrl_o(ctrl3), .sclk_i(sclk),
        .cs_n_i(cs_n), .rd_wr_i(rd_wr), .sdi_i(pin3), .sdo_o(sdo3), .sdo_oe_o(oe3));
    host_link_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .rd_wr_o(rd_wr),
        .sdi_o(sdi), .sdo5_i(pin5), .oe5_i(oe5), .sdo3_i(pin3), .oe3_i(oe3));
    // system clock, 50 ns
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // measures each busy phase in system cycles
    always @(posedge clk_sys_i) begin
        if (samp5 === 1'b1) samp_count <= samp_count + 1;
        if (st5.busy === 1'b1) begin
            run_q <= run_q + 1;
        end else begin
            if (run_q != 0) last_len <= run_q;
            run_q <= 0;
        end
    end
    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one comparison, counted
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // a wait that used up its bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            check(1'b0, "wait ran out");
            finish_test();
        end
    endtask
    // write a byte with n clocks and compare the control outputs
    task automatic t_write(input logic [7:0] v, input int n);
        i_host.write(v, n);
        check(ctrl5 === v && ctrl3 === v, "control byte");
        check(ch5 === v[7:5] && ch3 === v[7:5], "channel field");
    endtask
    // cut a read short and check both enables right after
    task automatic t_abort(input logic by_cs);
        logic o5, o3;
        i_host.abort(by_cs, o5, o3);
        check(o5 === 1'b0, "five-wire output not released");
        check(o3 === by_cs, "three-wire pin direction");
    endtask
    // one conversion, two with hold; hold keeps start low to power down, then wakes
    task automatic t_convert(input logic [9:0] c, input logic hold);
        int n;
        int s0;
        s0 = samp_count;
        code = c;
        start_n = 1'b0;
        repeat (adc_port_pkg::PWRUP_CYC) @(negedge clk_sys_i);
        if (!hold) start_n = 1'b1; // pulse lasts the power-up time
        for (n = 0; n < 400 && st5.valid !== 1'b1; n++) @(negedge clk_sys_i);
        bound(n, 400);
        @(negedge clk_sys_i);
        check(last_len == adc_port_pkg::CONV_CYC, "busy length");
        check(st3.valid === 1'b1, "three-wire result");
        check(st5.powered === !hold, "power state");
        if (hold) begin
            start_n = 1'b1;
            for (n = 0; n < 60 && st5.busy !== 1'b1; n++) @(negedge clk_sys_i);
            check(n >= adc_port_pkg::PWRUP_CYC && n < 48, "wake time");
            check(st5.powered === 1'b1, "powered on wake");
            for (n = 0; n < 400 && st5.busy === 1'b1; n++) @(negedge clk_sys_i);
            bound(n, 400);
            @(negedge clk_sys_i);
            check(last_len == adc_port_pkg::CONV_CYC, "busy after wake");
        end
        check(samp_count - s0 == (hold ? 2 : 1), "sample pulses");
        repeat (4) @(negedge clk_sys_i);
    endtask
    // read n bits; five-wire bits and clear judged only with chip select low
    task automatic t_read(input int n, input logic cs_hi, input logic [9:0] exp);
        logic [9:0] b5, b3, m;
        logic o5, o3;
        m = ~(10'h3ff >> n);
        i_host.read(n, cs_hi, b5, b3, o5, o3);
        check((b3 & m) === (exp & m), "three-wire bits");
        check(o3 === 1'b1 && o5 === !cs_hi, "enables in frame");
        if (!cs_hi) check((b5 & m) === (exp & m), "five-wire bits");
        check(oe5 === 1'b0 && oe3 === 1'b0, "released after read");
        repeat (6) @(negedge clk_sys_i); // quiet time after a read
        check(st3.valid === 1'b0, "result not cleared");
        if (!cs_hi) check(st5.valid === 1'b0, "result not cleared");
    endtask
    // run limit
    initial begin
        #2ms;
        check(1'b0, "run took too long");
        finish_test();
    end
    // main sequence
    initial begin
        repeat (8) @(negedge clk_sys_i);
        reset_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        check(ctrl5 === adc_port_pkg::CTRL_RST && ch5 === 3'h0, "reset channel");
        check(st5.busy === 1'b0 && st5.powered === 1'b1, "reset status");
        t_write(8'hb6, 10);
        t_write(8'h49, 8);
        t_abort(1'b1);
        t_abort(1'b0);
        @(negedge clk_sys_i);
        t_convert(10'h2c9, 1'b0);
        t_read(10, 1'b0, 10'h2c9);
        t_read(10, 1'b0, 10'h000);
        t_convert(10'h136, 1'b1);
        t_read(8, 1'b1, 10'h136);
        finish_test();
    end
endmodule // adc_result_serial_port_tb_top
